/* File: dcw_fifo.sv */
`default_nettype none

module dcw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = store[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
    end else begin
      if (push) begin
        next_wr_ptr = wr_ptr + 1'b1;
      end
      if (pop) begin
        next_rd_ptr = rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !flush) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule // dcw_fifo

`default_nettype wire

/* File: dcw_host_model.sv */
`default_nettype none

module dcw_host_model (
  input wire logic clk,
  input wire logic [7:0] char_drive,
  output logic wr_n,
  output logic cs,
  output logic cs_n,
  output logic mode,
  output logic [5:0] code,
  output logic a0,
  output logic a1,
  output logic a2,
  output logic a2_en
);
  timeunit 1ns;
  timeprecision 1ns;

  // Remembers whether the last write left the device in sequential entry
  logic seq_last;

  initial begin
    seq_last = 1'b0;
    wr_n = 1'b1;
    cs = 1'b1;
    cs_n = 1'b0;
    mode = 1'b0;
    code = 6'h00;
    {a2, a1, a0} = 3'h2;
    a2_en = 1'b0;
  end

  // Gate 1 drops the positive select, gate 2 raises the negative one
  task automatic wr(input logic m, input logic [2:0] a, input logic [5:0] c, input logic en,
                    input logic [1:0] gate, output logic [7:0] mid);
    @(posedge clk);
    #5;
    mode = m;
    wr_n = 1'b0;
    cs = (gate != 2'd1);
    cs_n = (gate == 2'd2);
    code = {3'h0, a};
    if (m) begin
      a0 = en;
      a1 = 1'b1;
      a2_en = 1'b0;
    end else begin
      {a2, a1, a0} = a;
      a2_en = !seq_last;
    end
    @(posedge clk);
    #5;
    code = c;
    if (!m) begin
      {a2, a1, a0} = 3'($urandom);
      a2_en = 1'b1;
    end
    @(posedge clk);
    @(posedge clk);
    #5;
    mid = char_drive;
    wr_n = 1'b1;
    cs = 1'b1;
    cs_n = 1'b0;
    @(posedge clk);
    #5;
    code = ~c;
    if (m) a1 = 1'b1;
    if (gate == 2'd0) seq_last = m;
  endtask

  task automatic pins(input logic m, input logic w);
    @(posedge clk);
    #5;
    mode = m;
    a1 = w;
  endtask
endmodule // dcw_host_model

`default_nettype wire

/* File: dcw_pkg.sv */
`default_nettype none

package dcw_pkg;
  typedef enum logic {
    RANDOM_ENTRY = 1'b0,
    SEQUENTIAL_ENTRY = 1'b1
  } dcw_mode_t;

  typedef enum logic [1:0] {
    DCW_IDLE = 2'b00,
    DCW_WRITING = 2'b01
  } dcw_wr_state_t;
endpackage

`default_nettype wire

/* File: dcw_port.sv */
`include "dcw_regs.svh"
`default_nettype none

module dcw_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_n,
  input wire logic cs,
  input wire logic cs_n,
  input wire logic mode,
  input wire logic [`DCW_CODE_W-1:0] char_code_in,
  input wire logic addr0_or_cascade_enable,
  input wire logic addr1_or_wipe_n,
  input wire logic addr2_or_full_flag_in,
  output logic addr2_or_full_flag_out,
  output logic addr2_or_full_flag_oe_n,
  input wire logic osc_or_shutdown,
  input wire logic scan_hold,
  output logic entry_ready,
  output logic [`DCW_POSITIONS-1:0] char_drive,
  output logic [`DCW_CODE_W-1:0] lamp_line_drive
);
  function automatic logic [`DCW_POSITIONS-1:0] pos_onehot(input logic [`DCW_POS_W-1:0] p);
    pos_onehot = 8'h01 << p;
  endfunction

  dcw_pkg::dcw_wr_state_t wr_state, next_wr_state;
  dcw_pkg::dcw_mode_t entry_mode, next_entry_mode;
  logic [`DCW_POS_W-1:0] addr_q, next_addr_q;
  logic cascade_q, next_cascade_q;
  logic [`DCW_CNT_W-1:0] seq_count, next_seq_count;
  logic full_drive, next_full_drive;
  logic [`DCW_CODE_W-1:0] mem [`DCW_POSITIONS];
  logic [`DCW_POS_W-1:0] scan_pos, next_scan_pos;
  logic [`DCW_SCAN_DIV_W-1:0] scan_div, next_scan_div;
  logic [`DCW_POSITIONS-1:0] next_char_drive;
  logic [`DCW_CODE_W-1:0] next_lamp;

  logic strobe;
  logic wr_fall;
  logic wr_rise;
  logic full;
  logic seq_mode;
  logic wipe;
  logic seq_enabled;
  logic push_valid;
  logic [`DCW_ENTRY_W-1:0] push_data;
  logic [`DCW_POS_W-1:0] target_pos;
  logic pop_valid;
  logic pop_ready;
  logic [`DCW_ENTRY_W-1:0] pop_data;
  logic write_blank;
  logic dark;

  assign strobe = !wr_n && cs && !cs_n;
  assign wr_fall = strobe && (wr_state == dcw_pkg::DCW_IDLE);
  assign wr_rise = !strobe && (wr_state == dcw_pkg::DCW_WRITING);
  assign full = seq_count[`DCW_FULL_BIT];
  assign seq_mode = (entry_mode == dcw_pkg::SEQUENTIAL_ENTRY);
  // Pin stays a wipe until the write start that returns to random entry
  assign wipe = seq_mode && !addr1_or_wipe_n;
  assign seq_enabled = cascade_q && !full;
  assign dark = !osc_or_shutdown;

  // Counter advances on the write end even when the entry queue is not
  // yet drained, so the position is fixed when the code is taken
  assign target_pos = seq_mode ? seq_count[`DCW_POS_W-1:0] : addr_q;
  assign push_valid = wr_rise && !wipe && (!seq_mode || seq_enabled);
  assign push_data = {target_pos, char_code_in};
  assign pop_ready = !scan_hold;
  assign write_blank = (wr_state == dcw_pkg::DCW_WRITING) && (!seq_mode || seq_enabled);

  assign addr2_or_full_flag_out = full && full_drive;
  assign addr2_or_full_flag_oe_n = !(full_drive && !dark);

  dcw_fifo #(
    .WIDTH(`DCW_ENTRY_W),
    .DEPTH(`DCW_FIFO_DEPTH)
  ) u_entry_fifo (
    .clk(clk),
    .reset(reset),
    .flush(wipe),
    .in_valid(push_valid),
    .in_ready(entry_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // Write sequencing and entry latches
  always_comb begin
    next_wr_state = wr_state;
    next_entry_mode = entry_mode;
    next_addr_q = addr_q;
    next_cascade_q = cascade_q;
    next_full_drive = full_drive;
    case (wr_state)
      dcw_pkg::DCW_IDLE: begin
        if (strobe) begin
          next_wr_state = dcw_pkg::DCW_WRITING;
          next_entry_mode = dcw_pkg::dcw_mode_t'(mode);
          if (!mode) begin
            next_addr_q = {addr2_or_full_flag_in, addr1_or_wipe_n,
                           addr0_or_cascade_enable};
            next_full_drive = 1'b0;
          end else begin
            next_cascade_q = addr0_or_cascade_enable;
          end
        end
      end
      dcw_pkg::DCW_WRITING: begin
        if (!strobe) begin
          next_wr_state = dcw_pkg::DCW_IDLE;
          if (seq_mode) begin
            next_full_drive = 1'b1;
          end
        end
      end
      default: begin
        next_wr_state = dcw_pkg::DCW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_state <= dcw_pkg::DCW_IDLE;
      entry_mode <= dcw_pkg::RANDOM_ENTRY;
      addr_q <= '0;
      cascade_q <= 1'b0;
      full_drive <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      entry_mode <= next_entry_mode;
      addr_q <= next_addr_q;
      cascade_q <= next_cascade_q;
      full_drive <= next_full_drive;
    end
  end

  // Sequential counter; wipe wins over a write ending in the same cycle
  always_comb begin
    next_seq_count = seq_count;
    if (wipe) begin
      next_seq_count = `DCW_CNT_RESET;
    end else if (seq_mode && push_valid && entry_ready) begin
      next_seq_count = seq_count + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      seq_count <= `DCW_CNT_RESET;
    end else begin
      seq_count <= next_seq_count;
    end
  end

  // Character memory; shutdown never touches it
  always_ff @(posedge clk) begin
    if (reset || wipe) begin
      for (int i = 0; i < `DCW_POSITIONS; i++) begin
        mem[i] <= `DCW_BLANK_CODE;
      end
    end else if (pop_valid && pop_ready) begin
      mem[pop_data[`DCW_ENTRY_W-1:`DCW_CODE_W]] <= pop_data[`DCW_CODE_W-1:0];
    end
  end

  // Multiplex scan; position drive from flops so it never glitches
  always_comb begin
    next_scan_div = scan_div + 6'h1;
    next_scan_pos = scan_pos;
    next_char_drive = pos_onehot(scan_pos);
    next_lamp = mem[scan_pos];
    if (scan_div == `DCW_SCAN_DIV_LAST) begin
      next_scan_pos = scan_pos + 3'h1;
    end
    if (dark) begin
      next_scan_div = '0;
      next_scan_pos = '0;
    end
    if (dark || write_blank) begin
      next_char_drive = '0;
      next_lamp = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scan_div <= '0;
      scan_pos <= '0;
      char_drive <= '0;
      lamp_line_drive <= '0;
    end else begin
      scan_div <= next_scan_div;
      scan_pos <= next_scan_pos;
      char_drive <= next_char_drive;
      lamp_line_drive <= next_lamp;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_mode_only_fall: assert property ($changed(entry_mode) |-> $past(wr_fall))
    else $error("entry mode changed outside a write start");
  a_mode_capture: assert property (wr_fall
    |=> entry_mode == dcw_pkg::dcw_mode_t'($past(mode)))
    else $error("entry mode not captured at write start");
  a_random_addr_latch: assert property (wr_fall && !mode |=> addr_q ==
    {$past(addr2_or_full_flag_in), $past(addr1_or_wipe_n), $past(addr0_or_cascade_enable)})
    else $error("random address not latched");
  a_seq_advance: assert property (wr_rise && seq_mode && seq_enabled
    && !wipe && entry_ready |=> seq_count == $past(seq_count) + 4'h1)
    else $error("counter did not advance on accepted entry");
  a_seq_refuse: assert property (wr_rise && seq_mode && !seq_enabled && !wipe
    |-> !push_valid ##1 $stable(seq_count))
    else $error("refused sequential write changed state");
  a_wipe_effect: assert property (wipe |=> seq_count == `DCW_CNT_RESET
    && mem[0] == `DCW_BLANK_CODE && mem[7] == `DCW_BLANK_CODE)
    else $error("wipe did not clear counter and memory");
  a_random_no_wipe: assert property (!seq_mode |-> !wipe ##1 $stable(seq_count))
    else $error("wipe active in random entry");
  a_full_flag: assert property (seq_count == `DCW_CNT_FULL && full_drive
    |-> addr2_or_full_flag_out)
    else $error("full flag low after eight entries");
  a_full_stands: assert property (full && !wipe |=> full)
    else $error("full flag fell without a wipe");
  a_strobe_end: assert property (wr_state == dcw_pkg::DCW_WRITING
    && (wr_n || !cs || cs_n) |=> wr_state == dcw_pkg::DCW_IDLE)
    else $error("write not ended by first disabling input");
  a_full_release: assert property (wr_fall && !mode |=> addr2_or_full_flag_oe_n)
    else $error("full flag still driven after switch to random");
  a_full_after_rise: assert property (wr_rise && seq_mode
    |=> full_drive && (addr2_or_full_flag_oe_n == dark))
    else $error("full flag not driven after sequential write");
  a_code_capture: assert property (push_valid |-> push_data[`DCW_CODE_W-1:0] == char_code_in)
    else $error("code not taken at write end");
  a_write_blank: assert property (write_blank |=> char_drive == '0 && lamp_line_drive == '0)
    else $error("drivers active during write");
  a_shutdown_dark: assert property (dark ##1 dark |-> char_drive == '0 && addr2_or_full_flag_oe_n)
    else $error("outputs active in shutdown");
endmodule // dcw_port

`default_nettype wire

/* File: dcw_regs.svh */
`ifndef DCW_REGS_SVH
`define DCW_REGS_SVH

`define DCW_POS_W 3
`define DCW_CODE_W 6
`define DCW_POSITIONS 8
`define DCW_CNT_W 4
`define DCW_CNT_RESET 4'h0
`define DCW_CNT_FULL 4'h8
`define DCW_FULL_BIT 3
`define DCW_BLANK_CODE 6'h20
`define DCW_FIFO_DEPTH 16
`define DCW_ENTRY_W 9
`define DCW_SCAN_DIV_W 6
`define DCW_SCAN_DIV_LAST 6'h3f

`endif

/* File: display_char_write_port_tb.sv */
`default_nettype none

module display_char_write_port_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, reset, osc, hold, wr_n, cs, cs_n, mode, a0, a1, a2, a2_en, a2_pin;
  logic full, oe_n, rdy;
  logic [5:0] code, lamp, c;
  logic [7:0] drv, mid;
  logic [2:0] p;
  logic [5:0] exp_mem [8];
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  // Undriven line shows a changing pattern so a stale value cannot pass
  assign a2_pin = !oe_n ? full : (a2_en ? a2 : cyc[0]);

  dcw_port i_dut (.clk(clk), .reset(reset), .wr_n(wr_n), .cs(cs), .cs_n(cs_n), .mode(mode),
    .char_code_in(code), .addr0_or_cascade_enable(a0), .addr1_or_wipe_n(a1),
    .addr2_or_full_flag_in(a2_pin), .addr2_or_full_flag_out(full),
    .addr2_or_full_flag_oe_n(oe_n), .osc_or_shutdown(osc), .scan_hold(hold),
    .entry_ready(rdy), .char_drive(drv), .lamp_line_drive(lamp));

  dcw_host_model i_host (.clk(clk), .char_drive(drv), .wr_n(wr_n), .cs(cs), .cs_n(cs_n),
    .mode(mode), .code(code), .a0(a0), .a1(a1), .a2(a2), .a2_en(a2_en));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      n_fail++;
    end
  endtask

  // Scan order is position 0 upward, so one sweep reads the whole memory
  task automatic read_all();
    int k;
    for (int q = 0; q < 8; q++) begin
      k = 0;
      while (drv !== (8'h01 << q) && k < 1500) begin
        @(posedge clk);
        #5;
        k++;
      end
      repeat (2) @(posedge clk);
      #5;
      chk("char_drive", 8'h01 << q, drv);
      chk($sformatf("pos%0d", q), {2'b00, exp_mem[q]}, {2'b00, lamp});
    end
  endtask

  initial begin
    reset = 1'b1;
    osc = 1'b1;
    hold = 1'b0;
    void'($urandom(31));
    repeat (10) @(posedge clk);
    #5;
    reset = 1'b0;
    chk("char_drive", 8'h00, drv);
    chk("oe_n", 8'h01, 8'(oe_n));
    chk("entry_ready", 8'h01, 8'(rdy));
    for (int i = 0; i < 8; i++) exp_mem[i] = 6'h20;
    hold = 1'b1;
    for (int i = 0; i < 16; i++) begin
      p = 3'($urandom);
      c = 6'($urandom);
      i_host.wr(1'b0, p, c, 1'b0, 2'd0, mid);
      chk("blank", 8'h00, mid);
      exp_mem[p] = c;
    end
    chk("entry_ready", 8'h00, 8'(rdy));
    i_host.wr(1'b0, 3'h2, ~exp_mem[2], 1'b0, 2'd0, mid);
    hold = 1'b0;
    repeat (20) @(posedge clk);
    #5;
    chk("entry_ready", 8'h01, 8'(rdy));
    i_host.wr(1'b0, 3'h5, ~exp_mem[5], 1'b0, 2'd1, mid);
    i_host.wr(1'b0, 3'h6, ~exp_mem[6], 1'b0, 2'd2, mid);
    i_host.pins(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    #5;
    chk("oe_n", 8'h01, 8'(oe_n));
    i_host.pins(1'b1, 1'b1);
    read_all();
    i_host.wr(1'b1, 3'h0, 6'h11, 1'b0, 2'd0, mid);
    for (int i = 0; i < 8; i++) begin
      c = 6'($urandom);
      i_host.wr(1'b1, 3'h0, c, 1'b1, 2'd0, mid);
      chk("blank", 8'h00, mid);
      exp_mem[i] = c;
      if (i == 0) chk("oe_n", 8'h00, 8'(oe_n));
      if (i == 6) chk("full", 8'h00, 8'(full));
    end
    repeat (2) @(posedge clk);
    #5;
    chk("full", 8'h01, 8'(full));
    i_host.wr(1'b1, 3'h0, 6'h3f, 1'b1, 2'd0, mid);
    read_all();
    i_host.pins(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    i_host.pins(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    #5;
    chk("full", 8'h00, 8'(full));
    for (int i = 0; i < 8; i++) exp_mem[i] = 6'h20;
    i_host.wr(1'b1, 3'h0, 6'h15, 1'b1, 2'd0, mid);
    exp_mem[0] = 6'h15;
    osc = 1'b0;
    repeat (3) @(posedge clk);
    #5;
    chk("char_drive", 8'h00, drv);
    chk("oe_n", 8'h01, 8'(oe_n));
    osc = 1'b1;
    // Switch back to random: bit 2 still shows the low full flag, bit 1 kept high
    i_host.wr(1'b0, 3'h2, 6'h2a, 1'b0, 2'd0, mid);
    exp_mem[2] = 6'h2a;
    chk("oe_n", 8'h01, 8'(oe_n));
    read_all();
    final_report();
  end
endmodule // display_char_write_port_tb

`default_nettype wire
